// >>> rtl/tpm_tracker.sv
// Telemetry readout with peak and minimum tracking for two channels
//
// Contract
// - Input-current peak holds the largest sample; 0x7C00 on reset, any clear, turn-on.
// - Input-current minimum holds the smallest; 0x7BFF on reset, any clear, turn-on.
// - Input-power peak holds the largest value; 0x7C00 on reset, clear, turn-on.
// - Input-power minimum holds the smallest value; 0x7BFF on reset, clear, turn-on.
// - Input-voltage peak holds the largest sample; 0x7C00 on reset, clear, turn-on.
// - Input-voltage minimum holds the smallest sample; 0x7BFF on reset, clear, turn-on.
// - Per channel output-voltage peak; 0xF800 on reset, own-page clear, own turn-on.
// - Per channel output-current peak; 0x7C00 on reset, own-page clear, own turn-on.
// - Per channel temperature peak; 0x7C00 on reset, own-page clear, own turn-on.
// - Page selects channel temperature; that value feeds all temperature work.
// - Invalid external temperature is replaced by the internal junction temperature.
// - Internal temperature is unpaged and feeds nothing except as a substitute.
// - Fixed-step current readout is signed 16-bit, one count per 2.5 mA.
// - Fixed-step current readout saturates at both extremes.
// - Sense readout is an unsigned 16-bit count, scale chosen by monitor select.
// - Sense readout holds the magnitude from the latest current conversion, uncompensated.
// - Peak and minimum values are returned by read-word commands in linear-11; output-voltage peaks in linear-16.
module tpm_tracker
	import tpm_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Conversion results
	input  wire logic         sample_valid,
	input  wire tpm_sample_t  sample,
	input  wire logic [1:0]   ext_temp_ok,
	// Channel state and fault clear
	input  wire logic [1:0]   chan_on,
	input  wire logic         clear_req,
	input  wire logic         clear_page,
	// Read-word port
	input  wire logic         rd_req,
	input  wire tpm_rd_req_t  rd_cmd,
	output logic              rd_ack,
	output logic              rd_unsup,
	output logic [15:0]       rd_data,
	// Temperature used by the rest of the device
	output logic [1:0][15:0]  temp_for_calc
);

	logic [1:0]        on_prev_reg;
	logic [1:0]        on_rise;
	logic [15:0]       vin_reg;
	logic [15:0]       iin_reg;
	logic [15:0]       pin_reg;
	logic [15:0]       itemp_reg;
	logic [1:0][15:0]  vout_reg;
	logic [1:0][15:0]  iout_reg;
	logic [1:0][15:0]  etemp_reg;
	logic [1:0][15:0]  step_reg;
	logic [1:0][15:0]  sense_reg;
	logic [1:0][15:0]  temp_calc_reg;
	logic [15:0]       temp_sel;
	logic [NCELL-1:0][15:0] cell_val;
	logic [15:0]       rd_data_next;
	logic              rd_hit;
	logic              rd_ack_reg;
	logic              rd_unsup_reg;
	logic [15:0]       rd_data_reg;

	// Channel off-to-on detect
	always_ff @(posedge clk) begin
		if (srst) begin
			on_prev_reg <= 2'h0;
		end else begin
			on_prev_reg <= chan_on;
		end
	end

	assign on_rise = chan_on & ~on_prev_reg;

	// Latest unpaged input measurements
	always_ff @(posedge clk) begin
		if (srst) begin
			vin_reg   <= 16'h0000;
			iin_reg   <= 16'h0000;
			pin_reg   <= 16'h0000;
			itemp_reg <= 16'h0000;
		end else if (sample_valid) begin
			case (sample.kind)
				K_VIN:   vin_reg   <= sample.data;
				K_IIN:   iin_reg   <= sample.data;
				K_PIN:   pin_reg   <= sample.data;
				K_ITEMP: itemp_reg <= sample.data;
				default: ;
			endcase
		end
	end

	// Latest per-channel measurements and derived readouts
	always_ff @(posedge clk) begin
		if (srst) begin
			vout_reg  <= '0;
			iout_reg  <= '0;
			etemp_reg <= '0;
			step_reg  <= '0;
			sense_reg <= '0;
		end else if (sample_valid) begin
			case (sample.kind)
				K_VOUT: vout_reg[sample.chan] <= sample.data;
				K_IOUT: begin
					iout_reg[sample.chan]  <= sample.data;
					step_reg[sample.chan]  <= tpm_l11_step(sample.data);
					sense_reg[sample.chan] <= sample.sense[15] ?
						16'(-sample.sense) : sample.sense;
				end
				K_ETEMP: etemp_reg[sample.chan] <= sample.data;
				default: ;
			endcase
		end
	end

	// Substitute the junction temperature for a failed external sensor
	always_ff @(posedge clk) begin
		if (srst) begin
			temp_calc_reg <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				temp_calc_reg[c] <= ext_temp_ok[c] ? etemp_reg[c] : itemp_reg;
			end
		end
	end

	assign temp_for_calc = temp_calc_reg;

	// Temperature sample as seen by the peak tracker
	always_comb begin
		temp_sel = ext_temp_ok[sample.chan] ? sample.data : itemp_reg;
	end

	// Peak and minimum trackers
	genvar g;
	generate
		for (g = 0; g < NCELL; g++) begin : g_cell
			logic        cell_clr;
			logic        cell_load;
			logic        cell_chan_ok;
			logic        cell_rise;
			logic [15:0] cell_in;

			// Input trackers follow any page and either channel
			if (CELL_SCOPE[g] == SCOPE_ALL) begin : g_all
				assign cell_chan_ok = 1'b1;
				assign cell_rise    = |on_rise;
				assign cell_clr     = clear_req | cell_rise;
			end else begin : g_chan
				assign cell_chan_ok = sample.chan == CELL_SCOPE[g][0];
				assign cell_rise    = on_rise[CELL_SCOPE[g][0]];
				assign cell_clr     = (clear_req && clear_page == CELL_SCOPE[g][0])
					|| cell_rise;
			end

			assign cell_load = sample_valid && sample.kind == CELL_KIND[g] && cell_chan_ok;
			assign cell_in   = (CELL_KIND[g] == K_ETEMP) ? temp_sel : sample.data;

			tpm_extreme_cell #(
				.SENTINEL (CELL_SENT[g]),
				.IS_MAX   (CELL_MAX[g]),
				.IS_L16   (CELL_L16[g])
			) u_cell (
				.clk    (clk),
				.srst   (srst),
				.clear  (cell_clr),
				.load   (cell_load),
				.sample (cell_in),
				.value  (cell_val[g])
			);
		end
	endgenerate

	// Read-word decode by command code and page
	always_comb begin
		rd_hit       = 1'b1;
		rd_data_next = 16'h0000;
		case (rd_cmd.cmd)
			CMD_VIN:        rd_data_next = vin_reg;
			CMD_IIN:        rd_data_next = iin_reg;
			CMD_PIN:        rd_data_next = pin_reg;
			CMD_VOUT:       rd_data_next = vout_reg[rd_cmd.page];
			CMD_IOUT:       rd_data_next = iout_reg[rd_cmd.page];
			CMD_TEMP1:      rd_data_next = temp_calc_reg[rd_cmd.page];
			CMD_TEMP2:      rd_data_next = itemp_reg;
			CMD_IOUT_STEP:  rd_data_next = step_reg[rd_cmd.page];
			CMD_SENSE_RAW:  rd_data_next = sense_reg[rd_cmd.page];
			CMD_IIN_HIGH:   rd_data_next = cell_val[C_IIN_HI];
			CMD_IIN_LOW:    rd_data_next = cell_val[C_IIN_LO];
			CMD_PIN_HIGH:   rd_data_next = cell_val[C_PIN_HI];
			CMD_PIN_LOW:    rd_data_next = cell_val[C_PIN_LO];
			CMD_VIN_HIGH:   rd_data_next = cell_val[C_VIN_HI];
			CMD_VIN_LOW:    rd_data_next = cell_val[C_VIN_LO];
			CMD_VOUT_HIGH:  rd_data_next = cell_val[C_VOUT_HI + int'(rd_cmd.page)];
			CMD_IOUT_HIGH:  rd_data_next = cell_val[C_IOUT_HI + int'(rd_cmd.page)];
			CMD_TEMP1_HIGH: rd_data_next = cell_val[C_TEMP_HI + int'(rd_cmd.page)];
			default:        rd_hit = 1'b0;
		endcase
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_ack_reg   <= 1'b0;
			rd_unsup_reg <= 1'b0;
			rd_data_reg  <= 16'h0000;
		end else begin
			rd_ack_reg   <= rd_req && rd_hit;
			rd_unsup_reg <= rd_req && !rd_hit;
			if (rd_req) begin
				rd_data_reg <= rd_data_next;
			end
		end
	end

	assign rd_ack   = rd_ack_reg;
	assign rd_unsup = rd_unsup_reg;
	assign rd_data  = rd_data_reg;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	logic quiet;
	assign quiet = !sample_valid && !clear_req && on_rise == 2'h0;

	iin_peak_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_IIN_HI] == SENT_PEAK
	) else $error("input current peak not reloaded");

	iin_min_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_IIN_LO] == SENT_MIN
	) else $error("input current minimum not reloaded");

	pin_peak_grow_a: assert property (
		sample_valid && sample.kind == K_PIN && !clear_req && on_rise == 2'h0
		|=> tpm_l11_fix(cell_val[C_PIN_HI]) >= tpm_l11_fix($past(sample.data))
	) else $error("input power peak below new sample");

	vin_min_hold_a: assert property (
		quiet |=> $stable(cell_val[C_VIN_LO])
	) else $error("input voltage minimum moved without cause");

	vout_page_only_a: assert property (
		clear_req && clear_page == 1'b1 && !sample_valid && on_rise == 2'h0
		|=> cell_val[C_VOUT_HI + 1] == SENT_VOUT_PEAK && $stable(cell_val[C_VOUT_HI])
	) else $error("output voltage peak clear scope wrong");

	temp_subst_a: assert property (
		!ext_temp_ok[1] ##1 !ext_temp_ok[1] |-> temp_for_calc[1] == $past(itemp_reg)
	) else $error("junction temperature not substituted");

	itemp_isolated_a: assert property (
		ext_temp_ok == 2'h3 ##1 ext_temp_ok == 2'h3 && $stable(etemp_reg)
		|=> $stable(temp_for_calc)
	) else $error("junction temperature leaked into channel temperature");

	step_sat_a: assert property (
		sample_valid && sample.kind == K_IOUT && sample.chan == 1'b1
		&& tpm_l11_fix(sample.data) > 42'sd5368709
		|=> step_reg[1] == STEP_POS_MAX
	) else $error("fixed-step current not saturated");

	sense_mag_a: assert property (
		sample_valid && sample.kind == K_IOUT && sample.chan == 1'b1 && sample.sense < 0
		|=> sense_reg[1] == 16'(-$past(sample.sense))
	) else $error("sense magnitude wrong");

	vin_peak_read_a: assert property (
		rd_req && rd_cmd.cmd == CMD_VIN_HIGH && quiet
		|=> rd_ack && rd_data == cell_val[C_VIN_HI] ##1 !rd_ack || $past(rd_req)
	) else $error("input voltage peak read wrong");

	peak_no_shrink_a: assert property (
		!clear_req && on_rise == 2'h0
		|=> tpm_l11_fix(cell_val[C_IIN_HI]) >= tpm_l11_fix($past(cell_val[C_IIN_HI]))
	) else $error("input current peak decreased");

	pin_peak_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_PIN_HI] == SENT_PEAK
	) else $error("input power peak not reloaded");

	pin_min_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_PIN_LO] == SENT_MIN
	) else $error("input power minimum not reloaded");

	vin_peak_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_VIN_HI] == SENT_PEAK
	) else $error("input voltage peak not reloaded");

	vin_min_clear_a: assert property (
		(clear_req || on_rise != 2'h0) && !sample_valid |=> cell_val[C_VIN_LO] == SENT_MIN
	) else $error("input voltage minimum not reloaded");

	vout_turn_on_a: assert property (
		on_rise[0] && !sample_valid |=> cell_val[C_VOUT_HI] == SENT_VOUT_PEAK
	) else $error("output voltage peak not reloaded at turn-on");

	iout_peak_clear_a: assert property (
		((clear_req && !clear_page) || on_rise[0]) && !sample_valid
		|=> cell_val[C_IOUT_HI] == SENT_PEAK
	) else $error("output current peak not reloaded");

	temp_peak_clear_a: assert property (
		((clear_req && clear_page) || on_rise[1]) && !sample_valid
		|=> cell_val[C_TEMP_HI + 1] == SENT_PEAK
	) else $error("temperature peak not reloaded");

	temp_ext_pass_a: assert property (
		ext_temp_ok[0] |=> temp_for_calc[0] == $past(etemp_reg[0])
	) else $error("channel temperature not taken from external sensor");

	step_exact_a: assert property (
		sample_valid && sample.kind == K_IOUT && sample.chan == 1'b1
		&& sample.data[15:11] == 5'h00 && sample.data[10:0] < 11'd82
		|=> step_reg[1] == 16'($past(sample.data[6:0])) * 16'd400
	) else $error("fixed-step current count wrong");

	step_neg_sat_a: assert property (
		sample_valid && sample.kind == K_IOUT && sample.chan == 1'b1
		&& tpm_l11_fix(sample.data) < -42'sd5368709
		|=> step_reg[1] == STEP_NEG_MAX
	) else $error("fixed-step current not saturated low");

	sense_pos_a: assert property (
		sample_valid && sample.kind == K_IOUT && sample.chan == 1'b1 && sample.sense >= 0
		|=> sense_reg[1] == 16'($past(sample.sense))
	) else $error("sense value wrong");

	read_answer_a: assert property (
		rd_req |=> rd_ack != rd_unsup
	) else $error("read request not answered once");

	read_idle_a: assert property (
		!rd_req |=> !rd_ack && !rd_unsup
	) else $error("read answer without request");

	vin_min_follow_a: assert property (
		sample_valid && sample.kind == K_VIN && !clear_req && on_rise == 2'h0
		|=> tpm_l11_fix(cell_val[C_VIN_LO]) <= tpm_l11_fix($past(sample.data))
	) else $error("input voltage minimum above new sample");

endmodule : tpm_tracker

// >>> rtl/tpm_pkg.sv
// Package: types, command codes, sentinels and tracker table for the telemetry tracker
package tpm_pkg;

	// Measurement kinds carried with each conversion result
	typedef enum logic [2:0] {
		K_VIN,
		K_IIN,
		K_PIN,
		K_VOUT,
		K_IOUT,
		K_ETEMP,
		K_ITEMP
	} tpm_kind_t;

	// One conversion result from the converter sequencer
	typedef struct packed {
		tpm_kind_t          kind;
		logic               chan;
		logic [15:0]        data;
		logic signed [15:0] sense;
	} tpm_sample_t;

	// One read-word request from the host interface
	typedef struct packed {
		logic [7:0] cmd;
		logic       page;
	} tpm_rd_req_t;

	// Read-word command codes
	localparam logic [7:0] CMD_VIN        = 8'h88;
	localparam logic [7:0] CMD_IIN        = 8'h89;
	localparam logic [7:0] CMD_PIN        = 8'h97;
	localparam logic [7:0] CMD_VOUT       = 8'h8B;
	localparam logic [7:0] CMD_IOUT       = 8'h8C;
	localparam logic [7:0] CMD_TEMP1      = 8'h8D;
	localparam logic [7:0] CMD_TEMP2      = 8'h8E;
	localparam logic [7:0] CMD_IOUT_STEP  = 8'hBB;
	localparam logic [7:0] CMD_IIN_HIGH   = 8'hC4;
	localparam logic [7:0] CMD_IIN_LOW    = 8'hC5;
	localparam logic [7:0] CMD_PIN_HIGH   = 8'hC6;
	localparam logic [7:0] CMD_PIN_LOW    = 8'hC7;
	localparam logic [7:0] CMD_SENSE_RAW  = 8'hFA;
	localparam logic [7:0] CMD_VIN_HIGH   = 8'hDE;
	localparam logic [7:0] CMD_VOUT_HIGH  = 8'hDD;
	localparam logic [7:0] CMD_IOUT_HIGH  = 8'hD7;
	localparam logic [7:0] CMD_TEMP1_HIGH = 8'hDF;
	localparam logic [7:0] CMD_VIN_LOW    = 8'hFC;

	// Sentinel codes loaded on reset and clear
	localparam logic [15:0] SENT_PEAK      = 16'h7C00;
	localparam logic [15:0] SENT_MIN       = 16'h7BFF;
	localparam logic [15:0] SENT_VOUT_PEAK = 16'hF800;

	// Fixed-step current format: counts per ampere and saturation limits
	localparam int          STEP_PER_AMP = 400;
	localparam logic [15:0] STEP_POS_MAX = 16'h7FFF;
	localparam logic [15:0] STEP_NEG_MAX = 16'h8000;

	// Tracker table: index, sentinel, direction, format, source, scope
	localparam int          NCELL     = 12;
	localparam logic [1:0]  SCOPE_ALL = 2'h2;
	localparam int          C_IIN_HI  = 0;
	localparam int          C_IIN_LO  = 1;
	localparam int          C_PIN_HI  = 2;
	localparam int          C_PIN_LO  = 3;
	localparam int          C_VIN_HI  = 4;
	localparam int          C_VIN_LO  = 5;
	localparam int          C_VOUT_HI = 6;
	localparam int          C_IOUT_HI = 8;
	localparam int          C_TEMP_HI = 10;
	localparam logic [15:0] CELL_SENT [NCELL] = '{SENT_PEAK, SENT_MIN, SENT_PEAK, SENT_MIN,
		SENT_PEAK, SENT_MIN, SENT_VOUT_PEAK, SENT_VOUT_PEAK, SENT_PEAK, SENT_PEAK,
		SENT_PEAK, SENT_PEAK};
	localparam bit          CELL_MAX  [NCELL] = '{1, 0, 1, 0, 1, 0, 1, 1, 1, 1, 1, 1};
	localparam bit          CELL_L16  [NCELL] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
	localparam tpm_kind_t   CELL_KIND [NCELL] = '{K_IIN, K_IIN, K_PIN, K_PIN, K_VIN, K_VIN,
		K_VOUT, K_VOUT, K_IOUT, K_IOUT, K_ETEMP, K_ETEMP};
	localparam logic [1:0]  CELL_SCOPE [NCELL] = '{SCOPE_ALL, SCOPE_ALL, SCOPE_ALL, SCOPE_ALL,
		SCOPE_ALL, SCOPE_ALL, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1};

	// Linear-11 word to exact signed fixed point, scaled by 2^16
	function automatic logic signed [41:0] tpm_l11_fix(input logic [15:0] w);
		logic signed [41:0] x;
		logic [4:0]         sh;
		x  = 42'(signed'(w[10:0]));
		sh = w[15:11] ^ 5'h10;
		return x <<< sh;
	endfunction : tpm_l11_fix

	// Linear-11 current to signed 2.5 mA counts, saturated
	function automatic logic [15:0] tpm_l11_step(input logic [15:0] w);
		logic signed [39:0] p;
		logic [4:0]         e;
		p = 40'(signed'(w[10:0])) * 40'(STEP_PER_AMP);
		e = w[15:11];
		if (e[4]) begin
			p = p >>> (5'h0 - e);
		end else begin
			p = p <<< e;
		end
		if (p > 40'(signed'(STEP_POS_MAX))) begin
			return STEP_POS_MAX;
		end else if (p < 40'(signed'(STEP_NEG_MAX))) begin
			return STEP_NEG_MAX;
		end else begin
			return p[15:0];
		end
	endfunction : tpm_l11_step

endpackage : tpm_pkg

// >>> rtl/tpm_extreme_cell.sv
// One stored peak or minimum value with its own compare
module tpm_extreme_cell
	import tpm_pkg::*;
#(
	parameter logic [15:0] SENTINEL = 16'h7C00,
	parameter bit          IS_MAX   = 1'b1,
	parameter bit          IS_L16   = 1'b0
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Control
	input  wire logic        clear,
	input  wire logic        load,
	input  wire logic [15:0] sample,
	// Stored value
	output logic [15:0]      value
);

	logic [15:0] value_reg;
	logic        fresh_reg;
	logic [15:0] base;
	logic        base_fresh;
	logic        better;

	// Sentinel is the comparison base on the clear cycle itself
	always_comb begin
		base       = clear ? SENTINEL : value_reg;
		base_fresh = clear | fresh_reg;
		if (IS_L16) begin
			// Unsigned words; a freshly cleared value counts as zero
			better = base_fresh ? (sample != 16'h0000) : (sample > base);
		end else if (IS_MAX) begin
			better = tpm_l11_fix(sample) > tpm_l11_fix(base);
		end else begin
			better = tpm_l11_fix(sample) < tpm_l11_fix(base);
		end
	end

	// Sample in the clear cycle is kept against the sentinel
	always_ff @(posedge clk) begin
		if (srst) begin
			value_reg <= SENTINEL;
			fresh_reg <= 1'b1;
		end else if (load && better) begin
			value_reg <= sample;
			fresh_reg <= 1'b0;
		end else if (clear) begin
			value_reg <= SENTINEL;
			fresh_reg <= 1'b1;
		end
	end

	assign value = value_reg;

endmodule : tpm_extreme_cell

// >>> tb/tpm_host_model.sv
// Host model issuing read-word requests to the tracker
module tpm_host_model
	import tpm_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Read-word port
	output logic             rd_req,
	output tpm_rd_req_t      rd_cmd,
	input  wire logic        rd_ack,
	input  wire logic        rd_unsup,
	input  wire logic [15:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rd_req = 1'b0;
		rd_cmd = '0;
	end

	// Standard current read once magnitudes leave the fixed-step range
	function automatic logic [7:0] pick_iout_cmd(input logic big);
		return big ? CMD_IOUT : CMD_IOUT_STEP;
	endfunction : pick_iout_cmd

	// One read-word transfer; answer taken 1 ns after the taking edge
	task automatic read_word(input logic [7:0] cmd, input logic page,
		output logic [15:0] data, output logic unsup, output logic timed_out);
		int n;
		@(posedge clk);
		rd_req <= 1'b1;
		rd_cmd <= '{cmd: cmd, page: page};
		@(posedge clk);
		rd_req <= 1'b0;
		timed_out = 1'b1;
		data = 16'h0000;
		unsup = 1'b0;
		for (n = 0; n < 4 && timed_out; n++) begin
			#1;
			if (rd_ack === 1'b1 || rd_unsup === 1'b1) begin
				data = rd_data;
				unsup = rd_unsup;
				timed_out = 1'b0;
			end else begin
				@(posedge clk);
			end
		end
	endtask : read_word
endmodule : tpm_host_model

// >>> tb/tpm_tracker_tb_top.sv
// Self-checking testbench for the telemetry tracker
module tpm_tracker_tb_top
	import tpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk;
	logic             srst;
	logic             sample_valid;
	tpm_sample_t      sample;
	logic [1:0]       ext_temp_ok;
	logic [1:0]       chan_on;
	logic             clear_req;
	logic             clear_page;
	logic             rd_req;
	tpm_rd_req_t      rd_cmd;
	logic             rd_ack;
	logic             rd_unsup;
	logic [15:0]      rd_data;
	logic [1:0][15:0] temp_for_calc;
	int               miscompares;
	int               checks_done;

	tpm_tracker DUT (.clk(clk), .srst(srst), .sample_valid(sample_valid), .sample(sample),
		.ext_temp_ok(ext_temp_ok), .chan_on(chan_on), .clear_req(clear_req),
		.clear_page(clear_page), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ack(rd_ack),
		.rd_unsup(rd_unsup), .rd_data(rd_data), .temp_for_calc(temp_for_calc));

	tpm_host_model host (.clk(clk), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ack(rd_ack),
		.rd_unsup(rd_unsup), .rd_data(rd_data));

	initial clk = 1'b0;
	always #2 clk = ~clk;

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk

	// Read one word and compare data and refusal flag
	task automatic rd(input logic [7:0] cmd, input logic page, input logic [15:0] exp,
		input logic exp_unsup = 1'b0);
		logic [15:0] d;
		logic        u;
		logic        t;
		host.read_word(cmd, page, d, u, t);
		if (t) begin
			miscompares++;
			give_verdict();
		end else begin
			chk($sformatf("read %h page %0d", cmd, page), exp, d);
			chk("unsupported flag", 16'(exp_unsup), 16'(u));
		end
	endtask : rd

	task automatic send(input tpm_kind_t k, input logic ch, input logic [15:0] d,
		input logic [15:0] s = 16'h0000);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample <= '{kind: k, chan: ch, data: d, sense: s};
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask : send

	logic [7:0]  in_hi [3] = '{CMD_VIN_HIGH, CMD_IIN_HIGH, CMD_PIN_HIGH};
	logic [7:0]  in_lo [3] = '{CMD_VIN_LOW, CMD_IIN_LOW, CMD_PIN_LOW};
	tpm_kind_t   in_k  [3] = '{K_VIN, K_IIN, K_PIN};

	task automatic check_inputs_cleared();
		for (int i = 0; i < 3; i++) begin
			rd(in_hi[i], 1'b0, SENT_PEAK);
			rd(in_lo[i], 1'b1, SENT_MIN);
		end
	endtask : check_inputs_cleared

	task automatic t_reset();
		chk("rd_data", 16'h0000, rd_data);
		chk("temp ch0", 16'h0000, temp_for_calc[0]);
		for (int p = 0; p < 2; p++) begin
			check_inputs_cleared();
			rd(CMD_VOUT_HIGH, p[0], SENT_VOUT_PEAK);
			rd(CMD_IOUT_HIGH, p[0], SENT_PEAK);
			rd(CMD_TEMP1_HIGH, p[0], SENT_PEAK);
		end
	endtask : t_reset

	task automatic t_input_track();
		logic [15:0] dv [5] = '{16'h0064, 16'h0032, 16'h0050, 16'h0819, 16'h0832};
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 5; j++) begin
				send(in_k[i], j[0], dv[j]);
			end
			rd(in_hi[i], 1'b1, 16'h0064);
			rd(in_lo[i], 1'b0, 16'h0032);
		end
	endtask : t_input_track

	task automatic t_chan_track();
		send(K_VOUT, 1'b0, 16'h1234);
		send(K_VOUT, 1'b1, 16'h0100);
		send(K_VOUT, 1'b0, 16'h1000);
		send(K_IOUT, 1'b0, 16'h0010, 16'hFE06);
		send(K_IOUT, 1'b1, 16'h0020, 16'h8000);
		send(K_ETEMP, 1'b0, 16'h0019);
		send(K_ETEMP, 1'b1, 16'h001E);
		rd(CMD_VOUT_HIGH, 1'b0, 16'h1234);
		rd(CMD_VOUT_HIGH, 1'b1, 16'h0100);
		rd(CMD_IOUT_HIGH, 1'b0, 16'h0010);
		rd(CMD_IOUT_HIGH, 1'b1, 16'h0020);
		rd(CMD_TEMP1_HIGH, 1'b0, 16'h0019);
		rd(CMD_TEMP1_HIGH, 1'b1, 16'h001E);
		rd(CMD_SENSE_RAW, 1'b0, 16'h01FA);
		rd(CMD_SENSE_RAW, 1'b1, 16'h8000);
	endtask : t_chan_track

	task automatic t_clear();
		@(posedge clk);
		clear_req <= 1'b1;
		clear_page <= 1'b1;
		@(posedge clk);
		clear_req <= 1'b0;
		check_inputs_cleared();
		rd(CMD_VOUT_HIGH, 1'b1, SENT_VOUT_PEAK);
		rd(CMD_VOUT_HIGH, 1'b0, 16'h1234);
		rd(CMD_IOUT_HIGH, 1'b1, SENT_PEAK);
		rd(CMD_IOUT_HIGH, 1'b0, 16'h0010);
		rd(CMD_TEMP1_HIGH, 1'b1, SENT_PEAK);
		rd(CMD_TEMP1_HIGH, 1'b0, 16'h0019);
		send(K_VOUT, 1'b1, 16'h0000);
		rd(CMD_VOUT_HIGH, 1'b1, SENT_VOUT_PEAK);
		send(K_VIN, 1'b0, 16'h0064);
		@(posedge clk);
		chan_on[0] <= 1'b0;
		@(posedge clk);
		chan_on[0] <= 1'b1;
		@(posedge clk);
		check_inputs_cleared();
		rd(CMD_VOUT_HIGH, 1'b0, SENT_VOUT_PEAK);
		rd(CMD_IOUT_HIGH, 1'b0, SENT_PEAK);
		rd(CMD_TEMP1_HIGH, 1'b0, SENT_PEAK);
	endtask : t_clear

	task automatic t_temp();
		@(posedge clk);
		ext_temp_ok <= 2'b01;
		send(K_ITEMP, 1'b0, 16'h0028);
		rd(CMD_TEMP1, 1'b0, 16'h0019);
		rd(CMD_TEMP1, 1'b1, 16'h0028);
		rd(CMD_TEMP2, 1'b0, 16'h0028);
		rd(CMD_TEMP2, 1'b1, 16'h0028);
		rd(CMD_TEMP1_HIGH, 1'b0, SENT_PEAK);
		chk("temp ch0", 16'h0019, temp_for_calc[0]);
		chk("temp ch1", 16'h0028, temp_for_calc[1]);
	endtask : t_temp

	task automatic t_step();
		logic [15:0] dv [5] = '{16'h0001, 16'h07FE, 16'hF803, 16'h0064, 16'h079C};
		logic [15:0] ev [5] = '{16'h0190, 16'hFCE0, 16'h0258, STEP_POS_MAX, STEP_NEG_MAX};
		for (int i = 0; i < 5; i++) begin
			send(K_IOUT, 1'b1, dv[i]);
			rd(CMD_IOUT_STEP, 1'b1, ev[i]);
		end
		rd(host.pick_iout_cmd(1'b1), 1'b1, 16'h079C);
		rd(8'hFB, 1'b0, 16'h0000, 1'b1);
		rd(8'h96, 1'b1, 16'h0000, 1'b1);
	endtask : t_step

	initial begin
		miscompares = 0;
		checks_done = 0;
		srst = 1'b1;
		sample_valid = 1'b0;
		sample = '0;
		ext_temp_ok = 2'b11;
		chan_on = 2'b11;
		clear_req = 1'b0;
		clear_page = 1'b0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_input_track();
		t_chan_track();
		t_clear();
		t_temp();
		t_step();
		give_verdict();
	end
endmodule : tpm_tracker_tb_top
